// [rtl/rpc_pkg.sv]
/*
  Shared constants for the read phase correction block: counter widths,
  the zeros-run threshold, buffer word layout and lock states.
  Assumes a single 200 MHz system clock and synchronous pulse inputs.
*/
`default_nettype none

package rpc_pkg;

  // ==========================================================
  // Zeros detector
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_TOP = 4'hF;
  localparam int CNT_HIT_BIT = 3;  // Binary 1000 reached

  // ==========================================================
  // Host word layout: one word per gated pulse event
  localparam int WORD_W = 2;
  localparam int WB_DATA = 0;
  localparam int WB_CLOCK = 1;

  // ==========================================================
  // Clock pulse delay, measured in system clock cycles
  localparam int DLY_W = 8;

  // ==========================================================
  // Lock states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HUNT = 3'b010,
    ST_LOCK = 3'b100
  } rpc_state_t;

endpackage

`default_nettype wire

// [rtl/rpc_buf_if.sv]
/*
  Carrier between the phase corrector core and its two-entry buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface rpc_buf_if #(
  parameter int W = rpc_pkg::WORD_W
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_word;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_word;

  // Buffer side
  modport buffer (
    input in_valid, in_word, out_ready,
    output in_ready, out_valid, out_word
  );
  // Core side
  modport core (
    output in_valid, in_word, out_ready,
    input in_ready, out_valid, out_word
  );
endinterface

`default_nettype wire

// [rtl/rpc_skid_buf.sv]
/*
  Two-entry skid buffer: an output stage plus one overflow entry.
  All outputs are registered. Assumes a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module rpc_skid_buf #(
  parameter int W = rpc_pkg::WORD_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Buffer port
  rpc_buf_if.buffer bif
);

  logic out_valid;
  logic [W-1:0] out_word;
  logic skid_valid;
  logic [W-1:0] skid_word;
  logic next_out_valid;
  logic [W-1:0] next_out_word;
  logic next_skid_valid;
  logic [W-1:0] next_skid_word;
  logic accept;
  logic drain;

  // ==========================================================
  // Next state: skid entry catches a word while output is stalled
  always_comb
  begin
    accept = bif.in_valid && !skid_valid;
    drain = out_valid && bif.out_ready;
    next_out_valid = out_valid;
    next_out_word = out_word;
    next_skid_valid = skid_valid;
    next_skid_word = skid_word;
    if (drain || !out_valid)
    begin
      if (skid_valid)
      begin
        next_out_valid = 1'b1;
        next_out_word = skid_word;
        next_skid_valid = 1'b0;
      end
      else
      begin
        next_out_valid = accept;
        next_out_word = bif.in_word;
      end
    end
    else if (accept)
    begin
      next_skid_valid = 1'b1;
      next_skid_word = bif.in_word;
    end
  end

  // Registers only
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_word <= '0;
      skid_valid <= 1'b0;
      skid_word <= '0;
    end
    else
    begin
      out_valid <= next_out_valid;
      out_word <= next_out_word;
      skid_valid <= next_skid_valid;
      skid_word <= next_skid_word;
    end
  end

  // Ready is a flop: full only when the skid entry holds a word
  assign bif.in_ready = !skid_valid;
  assign bif.out_valid = out_valid;
  assign bif.out_word = out_word;

endmodule

`default_nettype wire

// [rtl/rpc_core.sv]
/*
  Read phase correction: watches separated read pulses for a run of
  eight zeros, issues one realignment pulse when the separator windows
  are swapped, then locks and gates delayed pulses to the host.
  Assumes all inputs synchronous to mclk; reference clocks arrive as
  levels and are edge-detected here.
*/
// Contract
// - Two four-bit counters count straight up from zero to fifteen.
// - Data counter increments on data pulse, clears on clock pulse.
// - Clock counter increments on clock pulse, clears on data pulse.
// - Counters held at zero while loop-run is low.
// - Detect flops cleared, lock flop set while loop-run is low; the code clears the lock flop instead.
// - Loop-run rises on second file pulse after reading begins.
// - Detect and lock flops change only on reference edges.
// - Data counter at 1000 sets data detect on next double-rate rise.
// - Data detect with lock unset passes one realignment pulse.
// - Next reference edge after detect locks, clearing counters.
// - Read pulses reach the host only after lock.
// - Clock counter at 8 locks without any realignment pulse.
// - Each clock pulse delayed by one single-rate reference period.
// - Phase correction is for single-sector format; otherwise pass.
// - Pass-through forwards pulses unchanged, realignment inactive.
// - Realignment is an active-low pulse toggling the window flop.
// - Loop-run stays high until the host drops read gate.
`timescale 1ns/100ps
`default_nettype none

module rpc_core #(
  parameter int DLY_W = rpc_pkg::DLY_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Host control and variant select
  input wire logic read_gate,
  input wire logic passthrough_board,
  // From the data separator
  input wire logic sep_data,
  input wire logic sep_clock,
  input wire logic double_rate_ref,
  input wire logic single_rate_ref,
  // To the data separator
  output logic realign_n,
  output logic loop_run_flag,
  output logic phase_locked,
  // Host read stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic rd_data,
  output logic rd_clock
);

  // ==========================================================
  // Count helper: clear wins, then count up, else hold
  function automatic logic [3:0] cnt_next(input logic [3:0] cnt,
                                         input logic inc,
                                         input logic clr);
    if (clr)
      return rpc_pkg::CNT_ZERO;
    else if (inc)
      return cnt + rpc_pkg::CNT_ONE;
    else
      return cnt;
  endfunction

  rpc_buf_if #(.W(rpc_pkg::WORD_W)) bif ();

  logic sd_q;
  logic sc_q;
  logic dr_q;
  logic sr_q;
  logic first_seen;
  logic next_first_seen;
  logic next_loop_run;
  logic [3:0] data_cnt;
  logic [3:0] clk_cnt;
  logic [3:0] next_data_cnt;
  logic [3:0] next_clk_cnt;
  logic data_det;
  logic clk_det;
  logic next_data_det;
  logic next_clk_det;
  rpc_pkg::rpc_state_t state;
  rpc_pkg::rpc_state_t next_state;
  logic next_realign_n;
  logic [DLY_W-1:0] per_cnt;
  logic [DLY_W-1:0] per_len;
  logic [DLY_W-1:0] dly_cnt;
  logic [DLY_W-1:0] next_per_cnt;
  logic [DLY_W-1:0] next_per_len;
  logic [DLY_W-1:0] next_dly_cnt;
  logic pend_data;
  logic pend_clk;
  logic next_pend_data;
  logic next_pend_clk;
  logic dr_rise;
  logic dr_fall;
  logic sr_rise;
  logic hunting;
  logic cnt_clr;
  logic push;

  // ==========================================================
  // Input sampling and reference edges
  always_ff @(posedge mclk)
  begin
    // References track through reset, so release shows no false edge
    dr_q <= double_rate_ref;
    sr_q <= single_rate_ref;
    if (reset)
    begin
      sd_q <= 1'b0;
      sc_q <= 1'b0;
    end
    else
    begin
      sd_q <= sep_data;
      sc_q <= sep_clock;
    end
  end

  assign dr_rise = double_rate_ref && !dr_q;
  assign dr_fall = !double_rate_ref && dr_q;
  assign sr_rise = single_rate_ref && !sr_q;
  assign hunting = (state == rpc_pkg::ST_HUNT) && !passthrough_board;

  // ==========================================================
  // Loop-run flag: second file pulse under read gate, held until gate drops
  always_comb
  begin
    next_first_seen = first_seen;
    next_loop_run = loop_run_flag;
    if (!read_gate)
    begin
      next_first_seen = 1'b0;
      next_loop_run = 1'b0;
    end
    else if (sep_data || sep_clock)
    begin
      next_first_seen = 1'b1;
      if (first_seen)
        next_loop_run = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      first_seen <= 1'b0;
      loop_run_flag <= 1'b0;
    end
    else
    begin
      first_seen <= next_first_seen;
      loop_run_flag <= next_loop_run;
    end
  end

  // ==========================================================
  // Zeros detector and lock control
  // Counters stay cleared outside the hunt so a stale run cannot relock
  always_comb
  begin
    cnt_clr = !hunting || !loop_run_flag;
    next_data_cnt = cnt_next(data_cnt, sd_q && data_cnt != rpc_pkg::CNT_TOP,
                             cnt_clr || sc_q);
    next_clk_cnt = cnt_next(clk_cnt, sc_q && clk_cnt != rpc_pkg::CNT_TOP,
                            cnt_clr || sd_q);
    next_data_det = data_det;
    next_clk_det = clk_det;
    next_state = state;
    next_realign_n = 1'b1;
    unique case (state)
      rpc_pkg::ST_IDLE:
      begin
        next_data_det = 1'b0;
        next_clk_det = 1'b0;
        if (loop_run_flag)
          next_state = rpc_pkg::ST_HUNT;
      end
      rpc_pkg::ST_HUNT:
      begin
        if (dr_rise && data_cnt[rpc_pkg::CNT_HIT_BIT])
          next_data_det = 1'b1;
        if (dr_rise && clk_cnt[rpc_pkg::CNT_HIT_BIT])
          next_clk_det = 1'b1;
        if (data_det && double_rate_ref && !passthrough_board)
          next_realign_n = 1'b0;
        if (dr_fall && (data_det || clk_det))
          next_state = rpc_pkg::ST_LOCK;
      end
      rpc_pkg::ST_LOCK:
        next_state = rpc_pkg::ST_LOCK;
    endcase
    if (!loop_run_flag)
    begin
      next_state = rpc_pkg::ST_IDLE;
      next_data_det = 1'b0;
      next_clk_det = 1'b0;
    end
    if (passthrough_board)
      next_realign_n = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      data_cnt <= rpc_pkg::CNT_ZERO;
      clk_cnt <= rpc_pkg::CNT_ZERO;
      data_det <= 1'b0;
      clk_det <= 1'b0;
      state <= rpc_pkg::ST_IDLE;
      realign_n <= 1'b1;
      phase_locked <= 1'b0;
    end
    else
    begin
      data_cnt <= next_data_cnt;
      clk_cnt <= next_clk_cnt;
      data_det <= next_data_det;
      clk_det <= next_clk_det;
      state <= next_state;
      realign_n <= next_realign_n;
      phase_locked <= next_state == rpc_pkg::ST_LOCK;
    end
  end

  // ==========================================================
  // Clock pulse delay and gating to the buffer
  // Delay tracks the measured reference period; one pulse in flight,
  // which holds since clock pulses are a full bit cell apart
  always_comb
  begin
    push = bif.in_valid && bif.in_ready;
    next_per_cnt = per_cnt + 1'b1;
    next_per_len = per_len;
    if (sr_rise)
    begin
      next_per_cnt = '0;
      next_per_len = (per_cnt == '0) ? DLY_W'(1) : per_cnt + 1'b1;
    end
    next_dly_cnt = dly_cnt;
    next_pend_clk = pend_clk && !push;
    next_pend_data = pend_data && !push;
    if (dly_cnt > DLY_W'(1))
      next_dly_cnt = dly_cnt - 1'b1;
    else if (dly_cnt == DLY_W'(1))
    begin
      next_pend_clk = 1'b1;
      next_dly_cnt = '0;
    end
    if (passthrough_board)
    begin
      next_dly_cnt = '0;
      if (sd_q)
        next_pend_data = 1'b1;
      if (sc_q)
        next_pend_clk = 1'b1;
    end
    else if (state == rpc_pkg::ST_LOCK && loop_run_flag)
    begin
      if (sd_q)
        next_pend_data = 1'b1;
      if (sc_q)
        next_dly_cnt = (per_len == '0) ? DLY_W'(1) : per_len;
    end
    else
    begin
      next_dly_cnt = '0;
      next_pend_clk = 1'b0;
      next_pend_data = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      per_cnt <= '0;
      per_len <= '0;
      dly_cnt <= '0;
      pend_data <= 1'b0;
      pend_clk <= 1'b0;
    end
    else
    begin
      per_cnt <= next_per_cnt;
      per_len <= next_per_len;
      dly_cnt <= next_dly_cnt;
      pend_data <= next_pend_data;
      pend_clk <= next_pend_clk;
    end
  end

  // Pending flags stall until the buffer has room; a second pulse of the same kind merges into the held flag
  assign bif.in_valid = pend_data || pend_clk;
  assign bif.in_word = {pend_clk, pend_data};
  assign bif.out_ready = rd_ready;
  assign rd_valid = bif.out_valid;
  assign rd_data = bif.out_word[rpc_pkg::WB_DATA];
  assign rd_clock = bif.out_word[rpc_pkg::WB_CLOCK];

  rpc_skid_buf #(.W(rpc_pkg::WORD_W)) u_buf (
    .mclk(mclk),
    .reset(reset),
    .bif(bif)
  );

  // ==========================================================
  // Assertions
  AST_DATA_CNT_INC: assert property (@(posedge mclk) disable iff (reset)
    hunting && loop_run_flag && sd_q && !sc_q && data_cnt != 4'hF
    |=> data_cnt == $past(data_cnt) + 4'h1)
    else $error("data counter did not count");
  AST_DATA_CNT_CLR: assert property (@(posedge mclk) disable iff (reset)
    sc_q |=> data_cnt == 4'h0)
    else $error("data counter not cleared by clock pulse");
  AST_CLK_CNT_CLR: assert property (@(posedge mclk) disable iff (reset)
    sd_q |=> clk_cnt == 4'h0)
    else $error("clock counter not cleared by data pulse");
  AST_IDLE_HOLD: assert property (@(posedge mclk) disable iff (reset)
    !loop_run_flag |=> data_cnt == 4'h0 && clk_cnt == 4'h0
    && !data_det && !clk_det && !phase_locked)
    else $error("state not held while loop idle");
  AST_LOOP_RISE: assert property (@(posedge mclk) disable iff (reset)
    read_gate && first_seen && (sep_data || sep_clock)
    |=> loop_run_flag)
    else $error("loop-run did not rise on second pulse");
  AST_LOOP_HOLD: assert property (@(posedge mclk) disable iff (reset)
    loop_run_flag && read_gate |=> loop_run_flag)
    else $error("loop-run dropped under read gate");
  AST_DET_SET: assert property (@(posedge mclk) disable iff (reset)
    hunting && loop_run_flag && dr_rise && data_cnt[3]
    |=> data_det)
    else $error("data detect did not set");
  AST_REALIGN: assert property (@(posedge mclk) disable iff (reset)
    hunting && loop_run_flag && data_det && double_rate_ref
    |=> !realign_n)
    else $error("realignment pulse missing");
  AST_LOCK: assert property (@(posedge mclk) disable iff (reset)
    hunting && loop_run_flag && dr_fall && (data_det || clk_det)
    |=> phase_locked ##1 data_cnt == 4'h0 && clk_cnt == 4'h0)
    else $error("lock did not follow detect");
  AST_NO_REALIGN_LOCKED: assert property (@(posedge mclk)
    disable iff (reset)
    phase_locked ##1 phase_locked |-> realign_n)
    else $error("realignment after lock");
  AST_GATE: assert property (@(posedge mclk) disable iff (reset)
    bif.in_valid |-> phase_locked || passthrough_board
    || $past(passthrough_board))
    else $error("pulse passed before lock");
  AST_PASS: assert property (@(posedge mclk) disable iff (reset)
    passthrough_board |=> realign_n)
    else $error("realignment in pass-through");
  AST_LOCK_STAY: assert property (@(posedge mclk) disable iff (reset)
    phase_locked && loop_run_flag |=> phase_locked)
    else $error("lock released while loop running");
  COV_REALIGN: cover property (@(posedge mclk) disable iff (reset)
    !realign_n ##[1:100] phase_locked);
  COV_CLK_LOCK: cover property (@(posedge mclk) disable iff (reset)
    clk_det && !data_det ##[1:100] phase_locked);
  COV_STALL: cover property (@(posedge mclk) disable iff (reset)
    bif.in_valid && !bif.in_ready);

endmodule

`default_nettype wire

// [dv/rpc_host_model.sv]
/*
  Host controller model: owns the read gate and takes the gated read
  stream, ready always, at random, or never.
  Assumes rd_* outputs are registered on mclk.
*/
`timescale 1ns/100ps
`default_nettype none

module rpc_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Bench commands
  input wire logic gate_cmd,
  input wire logic [1:0] stall_mode,
  // Read stream
  input wire logic rd_valid,
  input wire logic rd_data,
  input wire logic rd_clock,
  output logic rd_ready,
  output logic read_gate,
  // Observed words
  output logic got,
  output logic [1:0] got_word
);
  // ========
  // Gate and ready change only just after an edge
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      read_gate <= 1'b0;
      rd_ready <= 1'b0;
    end
    else
    begin
      read_gate <= gate_cmd;
      // Random stalls test that the buffer loses no word
      if (stall_mode == 2'h0)
        rd_ready <= 1'b1;
      else if (stall_mode == 2'h1)
        rd_ready <= 1'($urandom_range(1));
      else
        rd_ready <= 1'b0;
    end
  end

  // A word is taken where valid meets ready
  assign got = rd_valid & rd_ready;
  assign got_word = {rd_clock, rd_data};
endmodule

`default_nettype wire

// [dv/read_phase_correction_bench.sv]
/*
  Bench for the read phase corrector: drives pulses and reference
  levels, keeps expected host words in a queue.
  Assumes rpc_host_model as the far side.
*/
`timescale 1ns/100ps
`default_nettype none

module read_phase_correction_bench;
  localparam int SR_PER = 16;  // Single-rate period in cycles
  logic mclk, reset, passthrough_board, sep_data, sep_clock;
  logic double_rate_ref, single_rate_ref, realign_n, loop_run_flag;
  logic phase_locked, rd_valid, rd_ready, rd_data, rd_clock;
  logic read_gate, gate_cmd, got, realign_q;
  logic [1:0] stall_mode, got_word;
  logic [31:0] cyc;
  logic [1:0] exp_q[$];
  int err_total, checked, lows, last_got, skip, gate_on;

  rpc_core dut (
    .mclk(mclk), .reset(reset), .read_gate(read_gate),
    .passthrough_board(passthrough_board), .sep_data(sep_data),
    .sep_clock(sep_clock), .double_rate_ref(double_rate_ref),
    .single_rate_ref(single_rate_ref), .realign_n(realign_n),
    .loop_run_flag(loop_run_flag), .phase_locked(phase_locked),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .rd_clock(rd_clock)
  );

  rpc_host_model host (
    .mclk(mclk), .reset(reset), .gate_cmd(gate_cmd),
    .stall_mode(stall_mode), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_clock(rd_clock), .rd_ready(rd_ready), .read_gate(read_gate),
    .got(got), .got_word(got_word)
  );

  // ========
  // Checking tasks
  task automatic cmp_val(input logic [1:0] a, input logic [1:0] e,
                         input string m);
    checked++;
    if (a !== e)
    begin
      err_total++;
      $display("[FAIL] %0t %s: got %b exp %b", $time, m, a, e);
    end
  endtask

  task automatic cmp_int(input int a, input int e, input string m);
    checked++;
    if (a != e)
    begin
      err_total++;
      $display("[FAIL] %0t %s: got %0d exp %0d", $time, m, a, e);
    end
  endtask

  task automatic close_out();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ========
  // Stimulus tasks
  // One-cycle pulse; expected word queued only when gating is on
  task automatic pulse(input logic d, input logic c, input int gap);
    @(posedge mclk);
    sep_data <= d;
    sep_clock <= c;
    if (gate_on)
      exp_q.push_back({c, d});
    @(posedge mclk);
    sep_data <= 1'b0;
    sep_clock <= 1'b0;
    repeat (gap) @(posedge mclk);
  endtask

  task automatic train(input logic d, input int n);
    repeat (n) pulse(d, !d, 1);
  endtask

  // Bounded wait, so a lock that never comes cannot hang the run
  task automatic wait_lock();
    int n = 0;
    while (phase_locked !== 1'b1 && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
  endtask

  // ========
  // Clock, references, scoreboard
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Double rate period 8 cycles, single rate 16
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    double_rate_ref <= cyc[2];
    single_rate_ref <= cyc[3];
    realign_q <= realign_n;
    if (!reset && realign_q === 1'b1 && realign_n === 1'b0)
      lows++;
    if (got === 1'b1 && phase_locked !== 1'b1 && !passthrough_board)
      cmp_val(got_word, 2'h0, "word before lock");
    if (got === 1'b1 && !skip)
    begin
      last_got = int'(cyc);
      if (exp_q.size() == 0)
        cmp_val(got_word, 2'h0, "unexpected word");
      else
        cmp_val(got_word, exp_q.pop_front(), "word");
    end
  end

  // Watchdog: whole run is well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    close_out();
  end

  // ========
  // Main sequence
  initial
  begin
    int t0, lat_d;
    logic d;
    reset = 1'b1;
    skip = 1;
    {passthrough_board, sep_data, sep_clock, gate_cmd} = 4'h0;
    {double_rate_ref, single_rate_ref, realign_q} = 3'h1;
    {cyc, stall_mode, err_total, checked, lows, gate_on} = '0;
    void'($urandom(51));
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    // No read gate: pulses must not start the loop
    train(1'b1, 12);
    repeat (4) @(posedge mclk);
    cmp_val({1'b0, loop_run_flag}, 2'h0, "run without gate");
    cmp_val({1'b0, phase_locked}, 2'h0, "lock without run");
    cmp_val({1'b0, realign_n}, 2'h1, "realign idle");
    // Swapped windows: zeros run shows on the data line
    gate_cmd <= 1'b1;
    repeat (3) @(posedge mclk);
    pulse(1'b1, 1'b0, 0);
    pulse(1'b1, 1'b0, 2);
    cmp_val({1'b0, loop_run_flag}, 2'h1, "loop run");
    train(1'b1, 14);
    wait_lock();
    cmp_val({1'b0, phase_locked}, 2'h1, "lock after swap");
    repeat (30) @(posedge mclk);
    cmp_int(lows, 1, "one realign pulse");
    train(1'b1, 10);
    repeat (30) @(posedge mclk);
    cmp_int(lows, 1, "no realign once locked");
    cmp_val({1'b0, phase_locked}, 2'h1, "lock holds");
    // Locked stream with random type, spacing and stalls
    skip = 0;
    gate_on = 1;
    stall_mode <= 2'h1;
    repeat (20)
    begin
      d = 1'($urandom_range(1));
      pulse(d, !d, 24 + $urandom_range(7));
    end
    repeat (40) @(posedge mclk);
    cmp_int(exp_q.size(), 0, "stream drained");
    // Clock words lag data words by one single-rate period
    stall_mode <= 2'h0;
    t0 = int'(cyc);
    pulse(1'b1, 1'b0, 40);
    lat_d = last_got - t0;
    t0 = int'(cyc);
    pulse(1'b0, 1'b1, 40);
    t0 = last_got - t0 - lat_d;
    cmp_int(int'(t0 >= SR_PER - 1 && t0 <= SR_PER + 1), 1, "delay");
    // Dropping the gate returns to the start state
    skip = 1;
    gate_on = 0;
    gate_cmd <= 1'b0;
    repeat (6) @(posedge mclk);
    cmp_val({1'b0, loop_run_flag}, 2'h0, "run drops");
    cmp_val({1'b0, phase_locked}, 2'h0, "lock clears");
    // Correct phase: zeros run on the clock line
    gate_cmd <= 1'b1;
    repeat (3) @(posedge mclk);
    train(1'b0, 16);
    wait_lock();
    cmp_val({1'b0, phase_locked}, 2'h1, "lock in phase");
    repeat (30) @(posedge mclk);
    cmp_int(lows, 1, "no realign in phase");
    gate_cmd <= 1'b0;
    repeat (6) @(posedge mclk);
    // Pass-through variant forwards at once, never realigns
    passthrough_board <= 1'b1;
    gate_cmd <= 1'b1;
    repeat (3) @(posedge mclk);
    skip = 0;
    gate_on = 1;
    stall_mode <= 2'h1;
    repeat (12)
    begin
      d = 1'($urandom_range(1));
      pulse(d, !d, 4 + $urandom_range(5));
    end
    repeat (20) @(posedge mclk);
    // Host stalled: two words buffered, one pending
    stall_mode <= 2'h2;
    train(1'b1, 3);
    repeat (10) @(posedge mclk);
    stall_mode <= 2'h0;
    repeat (20) @(posedge mclk);
    cmp_int(exp_q.size(), 0, "pass-through words");
    cmp_int(lows, 1, "no realign in pass-through");
    cmp_val({1'b0, phase_locked}, 2'h0, "no lock in pass");
    close_out();
  end
endmodule

`default_nettype wire
